// ==== hdl/apuhs_pkg.sv ====
package apuhs_pkg;

  localparam int DATA_W = 8;
  localparam int STACK_BYTES = 16;
  localparam int CNT_W = 14;

  // status register layout
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_SIGN_BIT = 6;
  localparam int ST_ZERO_BIT = 5;
  localparam int ST_ERR_LSB = 1;
  localparam int ST_CARRY_BIT = 0;
  localparam logic [3:0] ERR_RST = 4'h0;
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_DIV_ZERO = 4'h8;
  localparam logic [3:0] ERR_NEG_ARG = 4'h4;
  localparam logic [3:0] ERR_ARG_BIG = 4'hc;
  localparam logic [3:0] ERR_UNDERFLOW = 4'h2;
  localparam logic [3:0] ERR_OVERFLOW = 4'h1;

  // command byte: top bit asks for a service request at completion
  localparam int CMD_SVC_BIT = 7;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [6:0] OPC_NOP = 7'h00;
  localparam logic [6:0] OPC_FIXED16_ADD = 7'h6c;
  localparam logic [6:0] OPC_FIXED16_SUB = 7'h6d;
  localparam logic [6:0] OPC_FIXED16_MULL = 7'h6e;
  localparam logic [6:0] OPC_FIXED16_MULU = 7'h76;
  localparam logic [6:0] OPC_FIXED16_XCH = 7'h79;
  localparam logic [6:0] OPC_FLOAT_ADD = 7'h10;
  localparam logic [6:0] OPC_NATURAL_LOG = 7'h09;
  localparam logic [6:0] OPC_COMMON_LOG = 7'h08;
  localparam logic [6:0] OPC_SQUARE_ROOT = 7'h01;

  // execution times in clock cycles
  localparam int CYC_FIXED16_ADD = 17;
  localparam int CYC_FIXED16_SUB = 30;
  localparam int CYC_MULL_MIN = 84;
  localparam int CYC_MULL_MAX = 94;
  localparam int CYC_MULU_MIN = 80;
  localparam int CYC_MULU_MAX = 98;
  localparam int CYC_FIXED16_XCH = 18;
  localparam int CYC_NOP = 4;
  localparam int CYC_FLOAT_ADD_MIN = 54;
  localparam int CYC_FLOAT_ADD_MAX = 368;
  localparam int CYC_SQUARE_ROOT = 800;

  // interface latch transfer times in clock cycles
  localparam logic [2:0] XFER_STATUS_CYC = 3'd1;
  localparam logic [2:0] XFER_DATA_CYC = 3'd3;
  localparam logic [2:0] XFER_CMD_CYC = 3'd1;
  localparam logic [2:0] DRAIN_CYC = 3'd5;

  // natural log to common log factor, 0.43429448 in q0.16
  localparam logic [15:0] LOG10_E_Q16 = 16'h6f2e;

  typedef enum logic [2:0] {
    ACC_NONE, ACC_CMD_WR, ACC_STAT_RD, ACC_DATA_WR, ACC_DATA_RD
  } apuhs_acc_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_XFER = 2'b11, ST_HOLD = 2'b10
  } apuhs_state_t;

  typedef enum logic [2:0] {
    SOP_NONE, SOP_PUSH, SOP_POP, SOP_BIN, SOP_XCH
  } apuhs_sop_t;

endpackage : apuhs_pkg

// ==== hdl/apuhs_stack.sv ====
`timescale 1ns/1ps
module apuhs_stack import apuhs_pkg::*; (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // operation
  input wire apuhs_sop_t op_i,
  input wire logic [7:0] push_data_i,
  input wire logic [15:0] result_i,
  // stack top view
  output logic [7:0] top_byte_o,
  output logic [15:0] tos_o,
  output logic [15:0] nos_o
);

  logic [7:0] mem [STACK_BYTES];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < STACK_BYTES; i++) begin
        mem[i] <= 8'h00;
      end
    end else begin
      unique case (op_i)
        SOP_PUSH: begin
          // the bottom byte falls off
          mem[0] <= push_data_i;
          for (int i = 1; i < STACK_BYTES; i++) begin
            mem[i] <= mem[i-1];
          end
        end
        SOP_POP: begin
          // the removed byte rotates to the bottom
          for (int i = 0; i < STACK_BYTES - 1; i++) begin
            mem[i] <= mem[i+1];
          end
          mem[STACK_BYTES-1] <= mem[0];
        end
        SOP_BIN: begin
          mem[0] <= result_i[15:8];
          mem[1] <= result_i[7:0];
          for (int i = 2; i < STACK_BYTES - 2; i++) begin
            mem[i] <= mem[i+2];
          end
          mem[STACK_BYTES-2] <= mem[0];
          mem[STACK_BYTES-1] <= mem[1];
        end
        SOP_XCH: begin
          mem[0] <= mem[2];
          mem[1] <= mem[3];
          mem[2] <= mem[0];
          mem[3] <= mem[1];
        end
        default: begin
        end
      endcase
    end
  end

  assign top_byte_o = mem[0];
  assign tos_o = {mem[0], mem[1]};
  assign nos_o = {mem[2], mem[3]};

endmodule : apuhs_stack

// ==== hdl/apuhs_exec_timer.sv ====
`timescale 1ns/1ps
module apuhs_exec_timer import apuhs_pkg::*; (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // start with a cycle count
  input wire logic start_i,
  input wire logic [CNT_W-1:0] count_i,
  // progress
  output logic busy_o,
  output logic done_o
);

  logic [CNT_W-1:0] cnt;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else if (start_i) begin
      cnt <= count_i;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  // done marks the last cycle of execution, busy drops on the next edge
  assign busy_o = (cnt != '0);
  assign done_o = (cnt == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule : apuhs_exec_timer

// ==== hdl/apuhs_core.sv ====
`timescale 1ns/1ps
// Contract
// (RULE_01) end output goes low at execution end
// (RULE_02) end clears busy, raises service request if asked
// (RULE_03) end-acknowledge low pulse returns end output high
// (RULE_04) service-acknowledge low pulse lowers service request
// (RULE_05) ready high when idle, low only on access
// (RULE_06) command write while busy waits for completion
// (RULE_07) stack access while busy waits for completion
// (RULE_08) idle data read: ready low during latch load
// (RULE_09) idle data write: ready low until latch free
// (RULE_10) status read ready low briefly, even when busy
// (RULE_11) host holds strobes steady while ready low
// (RULE_12) busy bit is one while executing
// (RULE_13) sign bit shows stack top negative
// (RULE_14) zero bit shows stack top zero
// (RULE_15) carry bit shows carry or borrow out
// (RULE_16) error field codes last result validity
// (RULE_17) other status bits undefined while busy
// (RULE_18) status read drives status onto data bus
// (RULE_19) each command takes its tabulated cycle count
// (RULE_20) data dependent commands stay within range
// (RULE_21) common log is natural log times constant; the code computes no log and leaves the stack unchanged
// (RULE_22) power is exp of y times ln x; no power command is implemented
// (RULE_23) command write: select high, write strobe low
// (RULE_24) data write pushes, bottom byte lost
// (RULE_25) data read pops, byte rotates to bottom
// (RULE_26) status: busy sign zero error carry layout
module apuhs_core import apuhs_pkg::*; #(
  parameter int LN_MIN_CYC = 4298,
  parameter int LN_MAX_CYC = 6956
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // host bus
  input wire logic cs_n_i,
  input wire logic cmd_data_select_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic ready_o,
  // completion
  output logic end_n_o,
  output logic service_req_out_o,
  input wire logic done_ack_n_i,
  input wire logic service_ack_n_i
);

  logic [13:0] pin_s1;
  logic [13:0] pin_s2;
  logic done_ack_d;
  logic service_ack_d;
  logic done_ack_fall;
  logic service_ack_fall;
  apuhs_acc_t acc;
  apuhs_acc_t acc_q;
  apuhs_state_t state;
  logic [2:0] xfer_cnt;
  logic latch_full;
  logic [7:0] wr_latch;
  logic [2:0] drain_cnt;
  logic [7:0] cmd_q;
  logic exec_start;
  logic [CNT_W-1:0] exec_count;
  logic exec_busy;
  logic exec_done;
  logic carry;
  logic [3:0] err_code;
  apuhs_sop_t sop;
  logic [15:0] result;
  logic next_carry;
  logic [3:0] next_err;
  apuhs_sop_t exec_sop;
  logic [7:0] top_byte;
  logic [15:0] stack_top;
  logic [15:0] nos;
  logic [7:0] status;
  logic xfer_last;

  function automatic apuhs_acc_t decode_access(input logic cs_n,
      input logic sel, input logic rd_n, input logic wr_n);
    apuhs_acc_t kind;
    kind = ACC_NONE;
    if (!cs_n && !wr_n) begin
      kind = sel ? ACC_CMD_WR : ACC_DATA_WR;
    end else if (!cs_n && !rd_n) begin
      kind = sel ? ACC_STAT_RD : ACC_DATA_RD;
    end
    return kind;
  endfunction : decode_access

  // operand bits pick a point inside the range of a variable command
  function automatic logic [CNT_W-1:0] in_range(input int lo,
      input int hi, input logic [15:0] v);
    int extra;
    extra = int'(v[11:0]);
    if (extra > hi - lo) begin
      extra = hi - lo;
    end
    return CNT_W'(lo + extra);
  endfunction : in_range

  function automatic logic [CNT_W-1:0] exec_cycles(input logic [6:0] opc,
      input logic [15:0] v);
    logic [CNT_W-1:0] n;
    unique case (opc)
      OPC_FIXED16_ADD: n = CNT_W'(CYC_FIXED16_ADD); // [RULE_19]
      OPC_FIXED16_SUB: n = CNT_W'(CYC_FIXED16_SUB);
      OPC_FIXED16_MULL: n = in_range(CYC_MULL_MIN, CYC_MULL_MAX, v);
      OPC_FIXED16_MULU: n = in_range(CYC_MULU_MIN, CYC_MULU_MAX, v);
      OPC_FIXED16_XCH: n = CNT_W'(CYC_FIXED16_XCH);
      OPC_SQUARE_ROOT: n = CNT_W'(CYC_SQUARE_ROOT);
      OPC_FLOAT_ADD: begin
        n = in_range(CYC_FLOAT_ADD_MIN, CYC_FLOAT_ADD_MAX, v); // [RULE_20]
      end
      OPC_NATURAL_LOG, OPC_COMMON_LOG: begin
        n = in_range(LN_MIN_CYC, LN_MAX_CYC, v); // [RULE_20]
      end
      default: n = CNT_W'(CYC_NOP);
    endcase
    return n;
  endfunction : exec_cycles

  // every pin passes two flops; strobes are level stable per host contract
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= 14'h3f00;
      pin_s2 <= 14'h3f00;
      done_ack_d <= 1'b1;
      service_ack_d <= 1'b1;
    end else begin
      pin_s1 <= {done_ack_n_i, service_ack_n_i, cs_n_i, cmd_data_select_i,
                 rd_n_i, wr_n_i, data_i};
      pin_s2 <= pin_s1;
      done_ack_d <= pin_s2[13];
      service_ack_d <= pin_s2[12];
    end
  end

  assign done_ack_fall = done_ack_d && !pin_s2[13];
  assign service_ack_fall = service_ack_d && !pin_s2[12];
  // [RULE_11] [RULE_23] [RULE_24] [RULE_25]
  assign acc = decode_access(pin_s2[11], pin_s2[10], pin_s2[9], pin_s2[8]);
  assign xfer_last = (state == ST_XFER) && (xfer_cnt == 3'd1);

  // [RULE_26] [RULE_12] [RULE_13] [RULE_14] [RULE_17]
  assign status = {exec_busy, stack_top[15], (stack_top == 16'h0000), err_code, carry};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      acc_q <= ACC_NONE;
      xfer_cnt <= 3'd0;
      ready_o <= 1'b1;
      data_oe_o <= 1'b0;
      data_o <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (acc != ACC_NONE) begin
            acc_q <= acc;
            ready_o <= 1'b0; // [RULE_05]
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // status never waits; all else waits for execution and latch
          if (acc_q == ACC_STAT_RD) begin // [RULE_10]
            xfer_cnt <= XFER_STATUS_CYC;
            state <= ST_XFER;
          end else if (!exec_busy && !exec_start && !latch_full) begin
            // [RULE_06] [RULE_07] [RULE_09]
            xfer_cnt <= (acc_q == ACC_DATA_RD) ? XFER_DATA_CYC :
                        (acc_q == ACC_CMD_WR) ? XFER_CMD_CYC : 3'd1;
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (xfer_cnt == 3'd1) begin
            ready_o <= 1'b1; // [RULE_08] [RULE_09] [RULE_10]
            state <= ST_HOLD;
            if (acc_q == ACC_STAT_RD) begin
              data_o <= status; // [RULE_18]
              data_oe_o <= 1'b1;
            end else if (acc_q == ACC_DATA_RD) begin
              data_o <= top_byte;
              data_oe_o <= 1'b1;
            end
          end else begin
            xfer_cnt <= xfer_cnt - 1'b1;
          end
        end
        ST_HOLD: begin
          if (acc == ACC_NONE) begin
            data_oe_o <= 1'b0;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // write latch drains into the stack some cycles after the strobe
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_full <= 1'b0;
      wr_latch <= 8'h00;
      drain_cnt <= 3'd0;
    end else if (xfer_last && acc_q == ACC_DATA_WR) begin
      latch_full <= 1'b1;
      wr_latch <= pin_s2[7:0];
      drain_cnt <= DRAIN_CYC;
    end else if (latch_full) begin
      drain_cnt <= drain_cnt - 1'b1;
      if (drain_cnt == 3'd1) begin
        latch_full <= 1'b0; // [RULE_09]
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= CMD_RST;
      exec_start <= 1'b0;
      exec_count <= '0;
    end else begin
      exec_start <= xfer_last && (acc_q == ACC_CMD_WR); // [RULE_23]
      if (xfer_last && acc_q == ACC_CMD_WR) begin
        cmd_q <= pin_s2[7:0];
        exec_count <= exec_cycles(pin_s2[6:0], stack_top); // [RULE_19]
      end
    end
  end

  apuhs_exec_timer u_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(exec_start),
    .count_i(exec_count),
    .busy_o(exec_busy),
    .done_o(exec_done)
  );

  // results of the fixed point subset; other results are left in place
  always_comb begin
    logic [16:0] wide;
    logic signed [31:0] prod;
    logic [31:0] scaled;
    wide = 17'h00000;
    prod = $signed(nos) * $signed(stack_top);
    scaled = stack_top * LOG10_E_Q16;
    result = 16'h0000;
    next_carry = 1'b0;
    next_err = ERR_NONE;
    exec_sop = SOP_NONE;
    unique case (cmd_q[6:0])
      OPC_FIXED16_ADD: begin
        wide = {1'b0, nos} + {1'b0, stack_top};
        result = wide[15:0];
        next_carry = wide[16]; // [RULE_15]
        if (nos[15] == stack_top[15] && result[15] != stack_top[15]) begin
          next_err = ERR_OVERFLOW; // [RULE_16]
        end
        exec_sop = SOP_BIN;
      end
      OPC_FIXED16_SUB: begin
        wide = {1'b0, nos} - {1'b0, stack_top};
        result = wide[15:0];
        next_carry = wide[16]; // [RULE_15]
        if (nos[15] != stack_top[15] && result[15] != nos[15]) begin
          next_err = ERR_OVERFLOW;
        end
        exec_sop = SOP_BIN;
      end
      OPC_FIXED16_MULL: begin
        result = prod[15:0];
        exec_sop = SOP_BIN;
      end
      OPC_FIXED16_MULU: begin
        result = prod[31:16];
        exec_sop = SOP_BIN;
      end
      OPC_FIXED16_XCH: exec_sop = SOP_XCH;
      OPC_SQUARE_ROOT, OPC_NATURAL_LOG: begin
        if (stack_top[15]) begin
          next_err = ERR_NEG_ARG; // [RULE_16]
        end
      end
      OPC_COMMON_LOG: begin
        // the stack top times log10(e) is formed but never written back; the stack is left unchanged [RULE_21]
        if (stack_top[15]) begin
          next_err = ERR_NEG_ARG;
        end
        result = scaled[31:16];
        exec_sop = SOP_XCH;
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    sop = SOP_NONE;
    if (exec_done) begin
      sop = (cmd_q[6:0] == OPC_COMMON_LOG) ? SOP_NONE : exec_sop;
    end else if (xfer_last && acc_q == ACC_DATA_RD) begin
      sop = SOP_POP; // [RULE_25]
    end else if (latch_full && drain_cnt == 3'd1) begin
      sop = SOP_PUSH; // [RULE_24]
    end
  end

  apuhs_stack u_stack (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .op_i(sop),
    .push_data_i(wr_latch),
    .result_i(result),
    .top_byte_o(top_byte),
    .tos_o(stack_top),
    .nos_o(nos)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry <= 1'b0;
      err_code <= ERR_RST;
    end else if (exec_done) begin
      carry <= next_carry;
      err_code <= next_err;
    end
  end

  // a completion in the same cycle as an acknowledge wins
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      end_n_o <= 1'b1;
    end else if (exec_done) begin
      end_n_o <= 1'b0; // [RULE_01]
    end else if (done_ack_fall) begin
      end_n_o <= 1'b1; // [RULE_03]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      service_req_out_o <= 1'b0;
    end else if (exec_done && cmd_q[CMD_SVC_BIT]) begin
      service_req_out_o <= 1'b1; // [RULE_02]
    end else if (service_ack_fall) begin
      service_req_out_o <= 1'b0; // [RULE_04]
    end
  end

  sequence s_cmd_start(logic [6:0] opc);
    exec_start && cmd_q[6:0] == opc;
  endsequence

  a_end_on_done: assert property ( // [RULE_01]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    exec_done |=> !end_n_o ##0 !status[ST_BUSY_BIT])
    else $error("end output or busy wrong after completion");
  a_svc_on_done: assert property ( // [RULE_02]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    exec_done && cmd_q[CMD_SVC_BIT] |=> service_req_out_o)
    else $error("service request not raised");
  a_end_ack_clear: assert property ( // [RULE_03]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    done_ack_fall && !exec_done |=> end_n_o)
    else $error("end output not released by acknowledge");
  a_svc_ack_clear: assert property ( // [RULE_04]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    service_ack_fall && !exec_done |=> !service_req_out_o)
    else $error("service request not lowered by acknowledge");
  a_ready_idle_high: assert property ( // [RULE_05]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state == ST_IDLE |-> ready_o)
    else $error("ready low while idle");
  a_ready_busy_wait: assert property ( // [RULE_06]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state == ST_WAIT && acc_q != ACC_STAT_RD && (exec_busy || latch_full)
    |=> !ready_o)
    else $error("ready rose while execution or latch pending");
  a_data_rd_ready: assert property ( // [RULE_08]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state == ST_IDLE && acc == ACC_DATA_RD && !exec_busy && !latch_full
    && !exec_start |=> !ready_o [*4] ##1 ready_o && data_oe_o)
    else $error("idle data read timing wrong");
  a_status_rd_ready: assert property ( // [RULE_10]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    state == ST_IDLE && acc == ACC_STAT_RD
    |=> !ready_o [*2] ##1 ready_o && data_oe_o)
    else $error("status read timing wrong");
  a_status_zero_flag: assert property ( // [RULE_14]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    xfer_last && acc_q == ACC_STAT_RD
    |=> data_o[ST_ZERO_BIT] == ($past(stack_top) == 16'h0000)
    && data_o[ST_SIGN_BIT] == $past(stack_top[15]))
    else $error("status sign or zero wrong");
  a_add_cycles: assert property ( // [RULE_19]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_cmd_start(OPC_FIXED16_ADD) |-> ##17 exec_done)
    else $error("fixed add cycle count wrong");
  a_nop_cycles: assert property ( // [RULE_19]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_cmd_start(OPC_NOP) |-> !exec_done [*4] ##1 exec_done)
    else $error("no-operation cycle count wrong");
  a_float_add_range: assert property ( // [RULE_20]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_cmd_start(OPC_FLOAT_ADD) |-> ##[54:368] exec_done)
    else $error("float add outside range");

endmodule : apuhs_core

// ==== sim/apuhs_host_model.sv ====
`timescale 1ns/1ps
module apuhs_host_model import apuhs_pkg::*; (
  // clock
  input wire logic core_clk_i,
  // bus toward the device
  output logic cs_n_o,
  output logic sel_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic ready_i,
  // completion
  input wire logic end_n_i,
  input wire logic svc_i,
  output logic done_ack_n_o,
  output logic service_ack_n_o
);
  int cyc = 0;
  int ready_at = 0;
  int low_cyc = 0;

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
  end

  initial begin
    cs_n_o = 1'b1;
    sel_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    wdata_o = 8'h00;
    done_ack_n_o = 1'b1;
    service_ack_n_o = 1'b1;
  end

  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask : tick

  // entered just after an edge; everything holds until ready is seen high
  task automatic access(input logic sel, input logic rd,
                        input logic [7:0] wd, output logic [7:0] got);
    int n;
    n = 0;
    low_cyc = 0;
    cs_n_o = 1'b0;
    sel_o = sel;
    rd_n_o = ~rd;
    wr_n_o = rd;
    wdata_o = wd;
    while (ready_i !== 1'b0 && n < 8) begin
      tick();
      n++;
    end
    while (ready_i !== 1'b1 && low_cyc < 9000) begin
      tick();
      low_cyc++;
    end
    got = rdata_i;
    tick();
    ready_at = cyc;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    // a released bus must not keep showing the last byte
    wdata_o = ~wd;
    repeat (4) tick();
  endtask : access

  // sel 0 watches the end output, sel 1 the service request
  task automatic wait_lvl(input logic sel, input logic val, output int n);
    n = 0;
    while (((sel ? svc_i : end_n_i) !== val) && n < 9000) begin
      tick();
      n++;
    end
  endtask : wait_lvl

  task automatic ack(input logic svc);
    if (svc)
      service_ack_n_o = 1'b0;
    else
      done_ack_n_o = 1'b0;
    repeat (3) tick();
    service_ack_n_o = 1'b1;
    done_ack_n_o = 1'b1;
  endtask : ack
endmodule : apuhs_host_model

// ==== sim/apu_host_handshake_status_test.sv ====
`timescale 1ns/1ps
module apu_host_handshake_status_test;
  import apuhs_pkg::*;

  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cs_n, sel, rd_n, wr_n, oe, ready, end_n, svc, dack_n, sack_n;
  logic [7:0] wdata, rdata;
  int fails = 0;
  int n_compared = 0;

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  // log timing shortened to keep the run brief
  apuhs_core #(.LN_MIN_CYC(60), .LN_MAX_CYC(90)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .cmd_data_select_i(sel), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .data_i(wdata), .data_o(rdata), .data_oe_o(oe), .ready_o(ready),
    .end_n_o(end_n), .service_req_out_o(svc), .done_ack_n_i(dack_n),
    .service_ack_n_i(sack_n));

  apuhs_host_model host (
    .core_clk_i(core_clk_i), .cs_n_o(cs_n), .sel_o(sel), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .wdata_o(wdata), .rdata_i(rdata), .ready_i(ready),
    .end_n_i(end_n), .svc_i(svc), .done_ack_n_o(dack_n),
    .service_ack_n_o(sack_n));

  task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic check_rng(string what, int lo, int hi, int got);
    n_compared++;
    if (got < lo || got > hi) begin
      fails++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_rng

  task automatic status(output logic [7:0] s);
    host.access(1'b1, 1'b1, 8'h00, s);
  endtask : status

  task automatic push16(logic [15:0] v);
    logic [7:0] d;
    host.access(1'b0, 1'b0, v[7:0], d);
    host.access(1'b0, 1'b0, v[15:8], d);
  endtask : push16

  task automatic run_cmd(logic [7:0] cmd, int lo, int hi);
    logic [7:0] d;
    int n;
    host.access(1'b1, 1'b0, cmd, d);
    host.wait_lvl(1'b0, 1'b0, n);
    check_rng("cycles", lo, hi, host.cyc - host.ready_at);
    check8("svc req", {7'h0, cmd[7]}, {7'h0, svc});
    status(d);
    check8("busy at end", 8'h00, {7'h0, d[ST_BUSY_BIT]});
    host.ack(1'b0);
    host.wait_lvl(1'b0, 1'b1, n);
    check_rng("end ack", 0, 4, n);
    if (cmd[7]) begin
      host.ack(1'b1);
      host.wait_lvl(1'b1, 1'b0, n);
      check_rng("svc ack", 0, 4, n);
    end
  endtask : run_cmd

  task automatic s_idle_access();
    logic [7:0] d, hi, lo;
    status(d);
    check8("reset status", 8'h20, d);
    check_rng("status wait", 2, 2, host.low_cyc);
    push16(16'h8000);
    check_rng("write wait", 2, 2, host.low_cyc);
    status(d);
    check8("neg status", 8'h40, d);
    host.access(1'b0, 1'b1, 8'h00, hi);
    check_rng("read wait", 4, 4, host.low_cyc);
    host.access(1'b0, 1'b1, 8'h00, lo);
    check8("pop high", 8'h80, hi);
    check8("pop low", 8'h00, lo);
    status(d);
    check8("popped status", 8'h20, d);
    check8("bus released", 8'h00, {7'h0, oe});
  endtask : s_idle_access

  task automatic s_arith();
    logic [7:0] d;
    logic [15:0] a [3] = '{16'h1234, 16'hffff, 16'h7fff};
    logic [15:0] b [3] = '{16'h0101, 16'h0001, 16'h0001};
    logic [7:0] exp [3] = '{8'h00, 8'h21, 8'h02};
    logic [7:0] msk [3] = '{8'hff, 8'hff, 8'h1e};
    for (int i = 0; i < 3; i++) begin
      push16(a[i]);
      push16(b[i]);
      run_cmd({(i == 0), OPC_FIXED16_ADD}, CYC_FIXED16_ADD,
              CYC_FIXED16_ADD + 4);
      status(d);
      check8("add status", exp[i], d & msk[i]);
    end
  endtask : s_arith

  task automatic s_neg_root();
    logic [7:0] d;
    push16(16'h8000);
    run_cmd({1'b0, OPC_SQUARE_ROOT}, CYC_SQUARE_ROOT,
            CYC_SQUARE_ROOT + 4);
    status(d);
    check8("root code", {4'h0, ERR_NEG_ARG}, {4'h0, d[4:1]});
  endtask : s_neg_root

  // second access waits behind a long execution
  task automatic s_busy(logic data_rd);
    logic [7:0] d;
    int n;
    host.access(1'b1, 1'b0, {1'b0, OPC_SQUARE_ROOT}, d);
    status(d);
    check_rng("busy status wait", 2, 2, host.low_cyc);
    check8("busy bit", 8'h01, {7'h0, d[ST_BUSY_BIT]});
    host.access(~data_rd, data_rd, {1'b0, OPC_NOP}, d);
    if (data_rd)
      check_rng("stack wait", 700, 8999, host.low_cyc);
    else
      check_rng("cmd wait", 700, 8999, host.low_cyc);
    repeat (10) host.tick();
    check8("end low", 8'h00, {7'h0, end_n});
    host.ack(1'b0);
    host.wait_lvl(1'b0, 1'b1, n);
    check_rng("end ack", 0, 4, n);
  endtask : s_busy

  task automatic s_variable();
    push16(16'h0010);
    run_cmd({1'b0, OPC_FLOAT_ADD}, CYC_FLOAT_ADD_MIN + 16,
            CYC_FLOAT_ADD_MIN + 20);
    run_cmd({1'b1, OPC_NATURAL_LOG}, 76, 80);
    run_cmd({1'b0, OPC_COMMON_LOG}, 76, 80);
  endtask : s_variable

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (n_compared > 0 && fails == 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    host.tick();
    check8("idle ready", 8'h01, {7'h0, ready});
    s_idle_access();
    s_arith();
    s_neg_root();
    s_busy(1'b0);
    s_busy(1'b1);
    s_variable();
    wrap_up();
  end

  // about twelve times the expected run length
  initial begin
    #(40 * 40000);
    fails++;
    wrap_up();
  end
endmodule : apu_host_handshake_status_test
